// [hw/data_transfer_execution.v]
`timescale 1ns/1ps
`include "xfer_consts.vh"
module data_transfer_execution (
  // Clock, reset, enable
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire        clk_en_in,
  // Instruction request
  input  wire        start_in,
  input  wire [3:0]  op_in,
  input  wire [1:0]  size_sel_in,
  input  wire        word_attr_in,
  input  wire        seg_override_in,
  input  wire [1:0]  seg_override_sel_in,
  input  wire        iteration_prefix_in,
  input  wire        far_seg_extra_in,
  input  wire [15:0] operand_offset_in,
  input  wire [15:0] move_src_in,
  // Register file view
  input  wire [15:0] word_accumulator_in,
  input  wire [15:0] source_index_in,
  input  wire [15:0] destination_index_in,
  input  wire [15:0] count_register_in,
  input  wire [7:0]  bit_offset_in,
  input  wire [7:0]  field_len_in,
  input  wire        direction_flag_in,
  input  wire [7:0]  flags_in,
  // Memory bus
  input  wire        mem_ack_in,
  input  wire [15:0] mem_rdata_in,
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [1:0]  mem_seg_out,
  output reg  [15:0] mem_addr_out,
  output reg  [15:0] mem_wdata_out,
  output reg  [1:0]  mem_be_out,
  // Results
  output reg  [15:0] word_accumulator_out,
  output reg  [15:0] source_index_out,
  output reg  [15:0] destination_index_out,
  output reg  [15:0] count_register_out,
  output reg  [7:0]  bit_offset_out,
  output reg  [15:0] gen_reg_out,
  output reg         gen_reg_we_out,
  output reg  [15:0] data_seg_out,
  output reg         data_seg_we_out,
  output reg         data_seg_sel_out,
  output reg  [7:0]  flags_out,
  output reg         flags_we_out,
  output reg         irq_block_out,
  output reg         busy_out,
  output reg         done_out
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_READ  = 3'h1;
  localparam ST_WRITE = 3'h2;
  localparam ST_RMW_R = 3'h3;
  localparam ST_RMW_W = 3'h4;
  localparam ST_FAR_H = 3'h5;
  localparam ST_DONE  = 3'h6;

  reg [2:0]  state;
  reg [3:0]  op;
  reg        word;
  reg        iteration_prefix;
  reg [1:0]  src_seg;
  reg [3:0]  ofs;
  reg [3:0]  len;
  reg [31:0] fmask;
  reg [31:0] fdata;
  reg        fhi;

  wire [15:0] si_next;
  wire [15:0] di_next;
  wire        req_word;
  wire        block_op;
  wire [4:0]  ofs_sum;
  wire [31:0] len_mask;
  wire [31:0] field_shift;

  assign req_word = (size_sel_in == `SIZE_BYTE) ? 1'b0 :
                    (size_sel_in == `SIZE_WORD) ? 1'b1 : word_attr_in;
  assign block_op = (op == `OP_BLOCK_LOAD) || (op == `OP_BLOCK_COPY);
  assign ofs_sum  = {1'b0, ofs} + {1'b0, len} + 5'h01;
  assign len_mask = {16'h0000, (16'hffff >> (4'hf - len))};
  // Field bits spread over the word pair; upper half feeds the spill write
  assign field_shift = {16'h0000, word_accumulator_out} << ofs;

  index_step u_si_step (
    .index_in       (source_index_out),
    .word_in        (word),
    .dir_in         (direction_flag_in),
    .next_index_out (si_next)
  );
  index_step u_di_step (
    .index_in       (destination_index_out),
    .word_in        (word),
    .dir_in         (direction_flag_in),
    .next_index_out (di_next)
  );

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      op <= `OP_NONE;
      word <= 1'b0;
      iteration_prefix <= 1'b0;
      src_seg <= `SEG_PRIMARY;
      ofs <= 4'h0;
      len <= 4'h0;
      fmask <= 32'h0000_0000;
      fdata <= 32'h0000_0000;
      fhi <= 1'b0;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_seg_out <= `SEG_PRIMARY;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 16'h0000;
      mem_be_out <= 2'h0;
      word_accumulator_out <= 16'h0000;
      source_index_out <= 16'h0000;
      destination_index_out <= 16'h0000;
      count_register_out <= 16'h0000;
      bit_offset_out <= 8'h00;
      gen_reg_out <= 16'h0000;
      gen_reg_we_out <= 1'b0;
      data_seg_out <= 16'h0000;
      data_seg_we_out <= 1'b0;
      data_seg_sel_out <= 1'b0;
      flags_out <= 8'h00;
      flags_we_out <= 1'b0;
      irq_block_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else if (clk_en_in) begin
      done_out <= 1'b0;
      gen_reg_we_out <= 1'b0;
      data_seg_we_out <= 1'b0;
      flags_we_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            op <= op_in;
            word <= req_word;
            iteration_prefix <= iteration_prefix_in;
            src_seg <= seg_override_in ? seg_override_sel_in : `SEG_PRIMARY;
            word_accumulator_out <= word_accumulator_in;
            source_index_out <= source_index_in;
            destination_index_out <= destination_index_in;
            count_register_out <= count_register_in;
            bit_offset_out <= bit_offset_in;
            flags_out <= flags_in;
            irq_block_out <= 1'b0;
            busy_out <= 1'b1;
            ofs <= bit_offset_in[3:0];
            len <= field_len_in[3:0];
            case (op_in)
              `OP_FIELD_STORE: begin
                mem_seg_out <= seg_override_in ? seg_override_sel_in : `SEG_EXTRA;
                mem_addr_out <= destination_index_in;
                mem_we_out <= 1'b0;
                mem_req_out <= 1'b1;
                fhi <= 1'b0;
                state <= ST_RMW_R;
              end
              `OP_OFFSET_LOAD: begin
                gen_reg_out <= operand_offset_in;
                gen_reg_we_out <= 1'b1;
                state <= ST_DONE;
              end
              `OP_BLOCK_LOAD, `OP_BLOCK_COPY: begin
                if (iteration_prefix_in && (count_register_in == 16'h0000)) begin
                  // Zero count runs no element and must not wrap the count
                  iteration_prefix <= 1'b0;
                  state <= ST_DONE;
                end else begin
                  mem_seg_out <= seg_override_in ? seg_override_sel_in : `SEG_PRIMARY;
                  mem_addr_out <= source_index_in;
                  mem_be_out <= req_word ? 2'h3 : 2'h1;
                  mem_we_out <= 1'b0;
                  mem_req_out <= 1'b1;
                  state <= ST_READ;
                end
              end
              `OP_MOVE, `OP_MOVE_SREG: begin
                gen_reg_out <= move_src_in;
                gen_reg_we_out <= 1'b1;
                irq_block_out <= (op_in == `OP_MOVE_SREG);
                state <= ST_DONE;
              end
              `OP_FLAGS_TO_AH: begin
                // undefined bits are driven as zero
                word_accumulator_out[15:8] <= {flags_in[`FLAG_SIGN_BIT],
                  flags_in[`FLAG_ZERO_BIT], 1'b0, flags_in[`FLAG_HALF_BIT], 1'b0,
                  flags_in[`FLAG_PAR_BIT], 1'b0, flags_in[`FLAG_CARRY_BIT]};
                state <= ST_DONE;
              end
              `OP_AH_TO_FLAGS: begin
                flags_out[`FLAG_SIGN_BIT] <= word_accumulator_in[8 + `FLAG_SIGN_BIT];
                flags_out[`FLAG_ZERO_BIT] <= word_accumulator_in[8 + `FLAG_ZERO_BIT];
                flags_out[`FLAG_HALF_BIT] <= word_accumulator_in[8 + `FLAG_HALF_BIT];
                flags_out[`FLAG_PAR_BIT] <= word_accumulator_in[8 + `FLAG_PAR_BIT];
                flags_out[`FLAG_CARRY_BIT] <= word_accumulator_in[8 + `FLAG_CARRY_BIT];
                flags_we_out <= 1'b1;
                state <= ST_DONE;
              end
              `OP_FAR_LOAD: begin
                mem_seg_out <= seg_override_in ? seg_override_sel_in : `SEG_PRIMARY;
                mem_addr_out <= operand_offset_in;
                mem_be_out <= 2'h3;
                mem_we_out <= 1'b0;
                mem_req_out <= 1'b1;
                data_seg_sel_out <= far_seg_extra_in;
                state <= ST_READ;
              end
              default: state <= ST_DONE;
            endcase
          end
        end
        ST_READ: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            if (op == `OP_FAR_LOAD) begin
              gen_reg_out <= mem_rdata_in;
              gen_reg_we_out <= 1'b1;
              mem_addr_out <= mem_addr_out + 16'h0002;
              mem_req_out <= 1'b1;
              state <= ST_FAR_H;
            end else if (op == `OP_BLOCK_LOAD) begin
              if (word)
                word_accumulator_out <= mem_rdata_in;
              else
                word_accumulator_out[7:0] <= mem_rdata_in[7:0];
              source_index_out <= si_next;
              state <= ST_DONE;
            end else begin
              mem_seg_out <= `SEG_EXTRA;
              mem_addr_out <= destination_index_out;
              mem_wdata_out <= word ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
              mem_we_out <= 1'b1;
              mem_req_out <= 1'b1;
              state <= ST_WRITE;
            end
          end
        end
        ST_FAR_H: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            data_seg_out <= mem_rdata_in;
            data_seg_we_out <= 1'b1;
            state <= ST_DONE;
          end
        end
        ST_WRITE: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            source_index_out <= si_next;
            destination_index_out <= di_next;
            state <= ST_DONE;
          end
        end
        ST_RMW_R: begin
          // Read-modify-write of the word pair so a straddling field keeps neighbours
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            if (!fhi) begin
              fdata[15:0] <= mem_rdata_in;
              fmask <= len_mask << ofs;
              mem_addr_out <= mem_addr_out + `FIELD_IY_STEP;
              mem_req_out <= 1'b1;
              fhi <= 1'b1;
            end else begin
              fdata[31:16] <= mem_rdata_in;
              mem_addr_out <= destination_index_out;
              mem_wdata_out <= (fdata[15:0] & ~fmask[15:0]) |
                (field_shift[15:0] & fmask[15:0]);
              mem_be_out <= 2'h3;
              mem_we_out <= 1'b1;
              mem_req_out <= 1'b1;
              fhi <= 1'b0;
              state <= ST_RMW_W;
            end
          end
        end
        ST_RMW_W: begin
          if (mem_ack_in) begin
            if (!fhi && (fmask[31:16] != 16'h0000)) begin
              mem_addr_out <= mem_addr_out + `FIELD_IY_STEP;
              mem_wdata_out <= (fdata[31:16] & ~fmask[31:16]) |
                (field_shift[31:16] & fmask[31:16]);
              fhi <= 1'b1;
            end else begin
              mem_req_out <= 1'b0;
              mem_we_out <= 1'b0;
              if (ofs_sum > `FIELD_MAX_OFS) begin
                bit_offset_out <= {3'h0, ofs_sum - `FIELD_WRAP};
                destination_index_out <= destination_index_out + `FIELD_IY_STEP;
              end else begin
                bit_offset_out <= {3'h0, ofs_sum};
              end
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (iteration_prefix && block_op) begin
            count_register_out <= count_register_out - 16'h0001;
            if (count_register_out == 16'h0001) begin
              iteration_prefix <= 1'b0;
            end else begin
              mem_seg_out <= src_seg;
              mem_addr_out <= source_index_out;
              mem_be_out <= word ? 2'h3 : 2'h1;
              mem_we_out <= 1'b0;
              mem_req_out <= 1'b1;
              state <= ST_READ;
            end
            if (count_register_out == 16'h0001) begin
              done_out <= 1'b1;
              busy_out <= 1'b0;
              state <= ST_IDLE;
            end
          end else begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // data_transfer_execution

// [hw/xfer_consts.vh]
`ifndef XFER_CONSTS_VH
`define XFER_CONSTS_VH
// Operation codes on op_in
`define OP_NONE        4'h0
`define OP_FIELD_STORE 4'h1
`define OP_OFFSET_LOAD 4'h2
`define OP_BLOCK_LOAD  4'h3
`define OP_BLOCK_COPY  4'h4
`define OP_MOVE        4'h5
`define OP_MOVE_SREG   4'h6
`define OP_FLAGS_TO_AH 4'h7
`define OP_AH_TO_FLAGS 4'h8
`define OP_FAR_LOAD    4'h9
// Element size select on size_sel_in
`define SIZE_ATTR      2'h0
`define SIZE_BYTE      2'h1
`define SIZE_WORD      2'h2
// Segment codes
`define SEG_EXTRA      2'h0
`define SEG_CODE       2'h1
`define SEG_STACK      2'h2
`define SEG_PRIMARY    2'h3
// Flag byte bit positions
`define FLAG_SIGN_BIT  7
`define FLAG_ZERO_BIT  6
`define FLAG_HALF_BIT  4
`define FLAG_PAR_BIT   2
`define FLAG_CARRY_BIT 0
// Bit-field arithmetic
`define FIELD_WRAP     5'h10
`define FIELD_MAX_OFS  5'h0f
`define FIELD_IY_STEP  16'h0002
`endif

// [hw/index_step.v]
`timescale 1ns/1ps
// Next value of a block index: +/-1 for bytes, +/-2 for words
module index_step (
  // Operands
  input  wire [15:0] index_in,
  input  wire        word_in,
  input  wire        dir_in,
  // Result
  output wire [15:0] next_index_out
);
  wire [15:0] step;
  assign step           = word_in ? 16'h0002 : 16'h0001;
  assign next_index_out = dir_in ? (index_in - step) : (index_in + step);
endmodule // index_step

// [verif/data_transfer_execution_chk.sv]
`timescale 1ns/1ps
`include "xfer_consts.vh"
module data_transfer_execution_chk (
  // Watched ports
  input wire        sys_clk_in,
  input wire        rst_in,
  input wire        clk_en_in,
  input wire        start_in,
  input wire        busy_out,
  input wire [3:0]  op_in,
  input wire [1:0]  size_sel_in,
  input wire        seg_override_in,
  input wire [15:0] operand_offset_in,
  input wire [15:0] word_accumulator_in,
  input wire        mem_req_out,
  input wire        mem_we_out,
  input wire [1:0]  mem_seg_out,
  input wire [1:0]  mem_be_out,
  input wire [15:0] gen_reg_out,
  input wire        gen_reg_we_out,
  input wire [7:0]  flags_out,
  input wire        flags_we_out,
  input wire        irq_block_out,
  input wire        done_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_take(op);
    start_in && !busy_out && clk_en_in && op_in == op;
  endsequence
  sequence s_quiet_done;
    !mem_req_out throughout ##[0:1] done_out;
  endsequence
  a_offset_no_mem: assert property (s_take(`OP_OFFSET_LOAD) |=> s_quiet_done)
    else $error("offset load touched memory or finished late");
  a_offset_value: assert property (gen_reg_we_out && op_in == `OP_OFFSET_LOAD |->
    gen_reg_out == operand_offset_in) else $error("offset load wrote wrong value");
  a_flags_only: assert property (flags_we_out |-> op_in == `OP_AH_TO_FLAGS)
    else $error("flags written by a non flag move");
  a_flags_layout: assert property (flags_we_out |->
    (flags_out & 8'hd5) == (word_accumulator_in[15:8] & 8'hd5)) else $error("flag bits wrong");
  a_irq_shadow: assert property (done_out && op_in == `OP_MOVE_SREG |-> ##[0:1] irq_block_out)
    else $error("segment move left interrupts open");
  a_byte_lanes: assert property (mem_req_out && size_sel_in == `SIZE_BYTE &&
    (op_in == `OP_BLOCK_LOAD || op_in == `OP_BLOCK_COPY) |-> mem_be_out == 2'h1)
    else $error("byte block op used word lanes");
  a_field_seg: assert property (mem_req_out && op_in == `OP_FIELD_STORE && !seg_override_in
    |-> mem_seg_out == `SEG_EXTRA) else $error("field store in wrong segment");
  a_copy_dest: assert property (mem_req_out && mem_we_out && op_in == `OP_BLOCK_COPY
    |-> mem_seg_out == `SEG_EXTRA) else $error("copy destination in wrong segment");
  a_src_seg: assert property (mem_req_out && !mem_we_out && !seg_override_in &&
    (op_in == `OP_BLOCK_LOAD || op_in == `OP_BLOCK_COPY) |-> mem_seg_out == `SEG_PRIMARY)
    else $error("block source in wrong segment");
endmodule // data_transfer_execution_chk
bind data_transfer_execution data_transfer_execution_chk u_chk (.sys_clk_in, .rst_in,
  .clk_en_in, .start_in, .busy_out, .op_in, .size_sel_in, .seg_override_in,
  .operand_offset_in, .word_accumulator_in, .mem_req_out, .mem_we_out, .mem_seg_out,
  .mem_be_out, .gen_reg_out, .gen_reg_we_out, .flags_out, .flags_we_out, .irq_block_out,
  .done_out);

// [verif/xfer_mem_model.sv]
`timescale 1ns/1ps
module xfer_mem_model (
  // Control
  input  wire        sys_clk_in,
  input  wire        rst_in,
  input  wire        slow_in,
  // Processor bus
  input  wire        mem_req_in,
  input  wire        mem_we_in,
  input  wire [15:0] mem_addr_in,
  input  wire [15:0] mem_wdata_in,
  input  wire [1:0]  mem_be_in,
  output reg         mem_ack_out,
  output reg  [15:0] mem_rdata_out
);
  reg  [7:0] mem [0:255];
  reg  [1:0] wait_cnt;
  wire [7:0] lo = mem_addr_in[7:0];
  wire [7:0] hi = lo + 8'h1;
  // Read data toggles outside the ack cycle so stale data never looks valid
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 16'h0;
      wait_cnt <= 2'h0;
    end else if (mem_req_in && !mem_ack_out && (!slow_in || wait_cnt == 2'h3)) begin
      mem_ack_out <= 1'b1;
      wait_cnt <= 2'h0;
      mem_rdata_out <= {mem[hi], mem[lo]};
      if (mem_we_in && mem_be_in[0]) mem[lo] <= mem_wdata_in[7:0];
      if (mem_we_in && mem_be_in[1]) mem[hi] <= mem_wdata_in[15:8];
    end else begin
      mem_ack_out <= 1'b0;
      wait_cnt <= mem_req_in ? wait_cnt + 2'h1 : 2'h0;
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule // xfer_mem_model

// [verif/data_transfer_execution_tb.sv]
`timescale 1ns/1ps
`include "xfer_consts.vh"
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
  bad_count = bad_count + 1; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module data_transfer_execution_tb;
  reg         sys_clk_in, rst_in, clk_en_in, start_in, word_attr_in, seg_override_in, slow;
  reg         iteration_prefix_in, far_seg_extra_in, direction_flag_in;
  reg  [3:0]  op_in;
  reg  [1:0]  size_sel_in, seg_override_sel_in;
  reg  [15:0] operand_offset_in, move_src_in, word_accumulator_in, source_index_in;
  reg  [15:0] destination_index_in, count_register_in, e_acc, e_si, e_di;
  reg  [7:0]  bit_offset_in, field_len_in, flags_in;
  reg  [7:0]  rm [0:255];
  reg  [31:0] w, mk;
  wire        ack, req, we, gen_we, ds_we, ds_sel, fl_we, irq_blk, busy, done_out;
  wire [1:0]  seg, be;
  wire [15:0] rdata, addr, wdata, acc_o, si_o, di_o, cnt_o, gen_o, ds_o;
  wire [7:0]  bo_o, fl_o;
  integer     bad_count, num_checks, i, t, k, n, a, st, bo;
  data_transfer_execution u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .clk_en_in(clk_en_in), .start_in(start_in), .op_in(op_in), .size_sel_in(size_sel_in),
    .word_attr_in(word_attr_in), .seg_override_in(seg_override_in),
    .seg_override_sel_in(seg_override_sel_in), .iteration_prefix_in(iteration_prefix_in),
    .far_seg_extra_in(far_seg_extra_in), .operand_offset_in(operand_offset_in),
    .move_src_in(move_src_in), .word_accumulator_in(word_accumulator_in),
    .source_index_in(source_index_in), .destination_index_in(destination_index_in),
    .count_register_in(count_register_in), .bit_offset_in(bit_offset_in),
    .field_len_in(field_len_in), .direction_flag_in(direction_flag_in), .flags_in(flags_in),
    .mem_ack_in(ack), .mem_rdata_in(rdata), .mem_req_out(req), .mem_we_out(we),
    .mem_seg_out(seg), .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_be_out(be),
    .word_accumulator_out(acc_o), .source_index_out(si_o), .destination_index_out(di_o),
    .count_register_out(cnt_o), .bit_offset_out(bo_o), .gen_reg_out(gen_o),
    .gen_reg_we_out(gen_we), .data_seg_out(ds_o), .data_seg_we_out(ds_we),
    .data_seg_sel_out(ds_sel), .flags_out(fl_o), .flags_we_out(fl_we),
    .irq_block_out(irq_blk), .busy_out(busy), .done_out(done_out));
  xfer_mem_model u_mem (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .slow_in(slow),
    .mem_req_in(req), .mem_we_in(we), .mem_addr_in(addr), .mem_wdata_in(wdata),
    .mem_be_in(be), .mem_ack_out(ack), .mem_rdata_out(rdata));
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task go(input [3:0] op);
    integer c;
    begin
      c = 0;
      @(posedge sys_clk_in);
      op_in <= op;
      start_in <= 1'b1;
      @(posedge sys_clk_in);
      start_in <= 1'b0;
      #1;
      while (done_out !== 1'b1) begin
        c = c + 1;
        if (c > 200) begin
          bad_count = bad_count + 1;
          complete_run;
        end
        @(posedge sys_clk_in);
        #1;
      end
    end
  endtask
  initial begin
    {rst_in, clk_en_in} = 2'h3;
    {start_in, word_attr_in, seg_override_in, slow, iteration_prefix_in} = 5'h0;
    {far_seg_extra_in, direction_flag_in, op_in, size_sel_in, seg_override_sel_in} = 10'h0;
    {operand_offset_in, move_src_in, word_accumulator_in, source_index_in} = 64'h0;
    {destination_index_in, count_register_in, bit_offset_in, field_len_in} = 48'h0;
    flags_in = 8'h0;
    bad_count = 0;
    num_checks = 0;
    i = $urandom(13);
    for (i = 0; i < 256; i = i + 1) begin
      rm[i] = 8'($urandom);
      u_mem.mem[i] = rm[i];
    end
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    for (t = 0; t < 90; t = t + 1) begin
      k = $urandom_range(9, 1);
      @(posedge sys_clk_in);
      slow <= 1'($urandom);
      word_accumulator_in <= 16'($urandom);
      move_src_in <= 16'($urandom);
      source_index_in <= 16'(16 + 2 * $urandom_range(40, 0));
      destination_index_in <= 16'(130 + 2 * $urandom_range(35, 0));
      operand_offset_in <= 16'(16 + 2 * $urandom_range(90, 0));
      count_register_in <= 16'($urandom_range(3, 0));
      {iteration_prefix_in, direction_flag_in, word_attr_in} <= 3'($urandom);
      {seg_override_in, seg_override_sel_in, far_seg_extra_in} <= 4'($urandom);
      size_sel_in <= 2'($urandom_range(2, 0));
      bit_offset_in <= 8'($urandom_range(15, 0));
      field_len_in <= 8'($urandom_range(15, 0));
      flags_in <= 8'($urandom);
      go(k[3:0]);
      case (k)
        1: begin
          a = destination_index_in;
          w = {rm[a + 3], rm[a + 2], rm[a + 1], rm[a]};
          mk = ((32'h1 << (field_len_in + 1)) - 32'h1) << bit_offset_in;
          w = (w & ~mk) | (({16'h0, word_accumulator_in} << bit_offset_in) & mk);
          {rm[a + 3], rm[a + 2], rm[a + 1], rm[a]} = w;
          bo = bit_offset_in + field_len_in + 1;
          `CHK(bo_o, 8'(bo > 15 ? bo - 16 : bo))
          `CHK(di_o, 16'(bo > 15 ? a + 2 : a))
        end
        2: `CHK(gen_o, operand_offset_in)
        3, 4: begin
          st = (size_sel_in == `SIZE_WORD || (size_sel_in == `SIZE_ATTR && word_attr_in)) ? 2 : 1;
          n = iteration_prefix_in ? count_register_in : 1;
          {e_acc, e_si, e_di} = {word_accumulator_in, source_index_in, destination_index_in};
          for (i = 0; i < n; i = i + 1) begin
            if (k == 3)
              e_acc = (st == 2) ? {rm[e_si + 1], rm[e_si]} : {e_acc[15:8], rm[e_si]};
            else begin
              rm[e_di] = rm[e_si];
              if (st == 2) rm[e_di + 1] = rm[e_si + 1];
              e_di = direction_flag_in ? e_di - st : e_di + st;
            end
            e_si = direction_flag_in ? e_si - st : e_si + st;
          end
          `CHK(si_o, e_si)
          if (k == 3) `CHK(acc_o, e_acc)
          else `CHK(di_o, e_di)
          if (iteration_prefix_in) `CHK(cnt_o, 16'h0)
        end
        5, 6: begin
          `CHK(gen_o, move_src_in)
          `CHK(irq_blk, (k == 6))
          `CHK(fl_o, flags_in)
        end
        7: `CHK(acc_o, {flags_in & 8'hd5, word_accumulator_in[7:0]})
        8: `CHK(fl_o, (word_accumulator_in[15:8] & 8'hd5) | (flags_in & 8'h2a))
        9: begin
          a = operand_offset_in;
          `CHK(gen_o, {rm[a + 1], rm[a]})
          `CHK(ds_o, {rm[a + 3], rm[a + 2]})
          `CHK(ds_sel, far_seg_extra_in)
        end
        default: ;
      endcase
      for (i = 0; i < 256; i = i + 1) `CHK(u_mem.mem[i], rm[i])
    end
    complete_run;
  end
endmodule // data_transfer_execution_tb
